// ===== src/pmrf_pkg.sv
package pmrf_pkg;
	// =====================================================
	// register offsets
	localparam logic [7:0] PMRF_ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] PMRF_ADDR_BROWNOUT_CONTROL = 8'hA3;
	localparam logic [7:0] PMRF_ADDR_UNLOCK = 8'hC7;
	localparam logic [7:0] PMRF_ADDR_IRQ_STATUS = 8'hF0;
	localparam logic [7:0] PMRF_ADDR_IRQ_MASK = 8'hF1;
	localparam logic [7:0] PMRF_ADDR_RESET_CAUSE = 8'hF2;
	// =====================================================
	// power control fields
	localparam int PMRF_BIT_IDLE = 0;
	localparam int PMRF_BIT_PDOWN = 1;
	localparam int PMRF_BIT_COLD = 4;
	localparam logic [7:0] PMRF_POWER_CONTROL_RESET = 8'h10;
	localparam logic [7:0] PMRF_POWER_CONTROL_WMASK = 8'hDF;
	// =====================================================
	// brown-out control fields
	localparam int PMRF_BIT_BOR_FLAG = 1;
	localparam int PMRF_BIT_BOR_EN = 2;
	localparam int PMRF_BIT_BO_EVENT = 3;
	localparam int PMRF_BIT_BO_STATE = 0;
	localparam logic [7:0] PMRF_BOD_RESET = 8'h00;
	localparam logic [7:0] PMRF_BOD_WMASK = 8'hFE;
	// =====================================================
	// unlock sequence bytes
	localparam logic [7:0] PMRF_UNLOCK_KEY1 = 8'hAA;
	localparam logic [7:0] PMRF_UNLOCK_KEY2 = 8'h55;
	localparam int PMRF_UNLOCK_WINDOW = 4;
	// =====================================================
	// interrupt status bits
	localparam int PMRF_IRQ_WAKE = 0;
	localparam int PMRF_IRQ_BROWNOUT = 1;
	localparam int PMRF_IRQ_RESET = 2;
	localparam int PMRF_IRQ_W = 3;
	// =====================================================
	// reset cause codes and fetch address
	localparam logic [2:0] PMRF_CAUSE_POR = 3'h0;
	localparam logic [2:0] PMRF_CAUSE_BOR = 3'h1;
	localparam logic [2:0] PMRF_CAUSE_PIN = 3'h2;
	localparam logic [2:0] PMRF_CAUSE_WDT = 3'h3;
	localparam logic [2:0] PMRF_CAUSE_SW = 3'h4;
	localparam logic [15:0] PMRF_RESET_VECTOR = 16'h0000;
	// =====================================================
	// oscillator settling
	localparam int PMRF_OSC_SETTLE_NS = 200;
	localparam int PMRF_CLK_PERIOD_NS = 5;
	localparam int PMRF_OSC_SETTLE_CYC = (PMRF_OSC_SETTLE_NS + PMRF_CLK_PERIOD_NS - 1)
		/ PMRF_CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		PMRF_RUN = 4'h1,
		PMRF_IDLE = 4'h2,
		PMRF_PDOWN = 4'h4,
		PMRF_SETTLE = 4'h8
	} pmrf_state_e;
endpackage : pmrf_pkg

// ===== src/pmrf_top.sv
`timescale 1ns/1ps
`default_nettype none
module pmrf_top
	import pmrf_pkg::*;
#(
	parameter int SETTLE_CYC = PMRF_OSC_SETTLE_CYC
) (
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	// power and reset sources
	input wire logic SUPPLY_OK_I,
	input wire logic PIN_RESET_I,
	input wire logic WDT_RESET_I,
	input wire logic SW_RESET_I,
	input wire logic BROWNOUT_DETECT_I,
	// interrupt sources: enabled pending lines
	input wire logic INT_PENDING_I,
	input wire logic [5:0] PDOWN_WAKE_I,
	// register port
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	// system controls
	output logic CORE_RESET_O,
	output logic CPU_CLK_EN_O,
	output logic PERIPH_CLK_EN_O,
	output logic OSC_EN_O,
	output logic WAKE_SERVICE_O,
	output logic [15:0] FETCH_ADDR_O,
	output logic [2:0] RESET_CAUSE_O,
	output logic IRQ_O
);
	// =====================================================
	// state
	pmrf_state_e state_q, state_d;
	logic [7:0] power_control_q;
	logic [7:0] bod_q;
	logic [1:0] unlock_q;
	logic [2:0] unlock_cnt_q;
	logic [15:0] settle_q;
	logic [2:0] cause_q;
	logic [PMRF_IRQ_W-1:0] irq_st_q, irq_mask_q;
	logic in_reset_q;
	logic from_pdown_q;
	logic [7:0] rdata_q;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction : hit

	// =====================================================
	// decode
	wire wr_power_control = WR_I && hit(ADDR_I, PMRF_ADDR_POWER_CONTROL);
	wire wr_bod = WR_I && hit(ADDR_I, PMRF_ADDR_BROWNOUT_CONTROL);
	wire wr_unlock = WR_I && hit(ADDR_I, PMRF_ADDR_UNLOCK);
	wire wr_ist = WR_I && hit(ADDR_I, PMRF_ADDR_IRQ_STATUS);
	wire wr_imask = WR_I && hit(ADDR_I, PMRF_ADDR_IRQ_MASK);
	wire unlocked = unlock_q[1];
	wire bod_wr_ok = wr_bod && unlocked;
	wire bor_fire = BROWNOUT_DETECT_I && bod_q[PMRF_BIT_BOR_EN];
	// supply low holds reset as power-on
	wire por = !RST_N_I || !SUPPLY_OK_I;
	wire any_reset = por || bor_fire || PIN_RESET_I || WDT_RESET_I || SW_RESET_I;
	wire [2:0] cause_now = por ? PMRF_CAUSE_POR :
		bor_fire ? PMRF_CAUSE_BOR :
		PIN_RESET_I ? PMRF_CAUSE_PIN :
		WDT_RESET_I ? PMRF_CAUSE_WDT : PMRF_CAUSE_SW;
	wire pd_wake = |PDOWN_WAKE_I;
	wire idle_wake = INT_PENDING_I || pd_wake;
	wire [PMRF_IRQ_W-1:0] irq_ev;
	assign irq_ev[PMRF_IRQ_WAKE] = (state_q == PMRF_SETTLE && settle_q == 16'h0000)
		|| (state_q == PMRF_IDLE && idle_wake);
	assign irq_ev[PMRF_IRQ_BROWNOUT] = BROWNOUT_DETECT_I && !bod_q[PMRF_BIT_BO_EVENT];
	assign irq_ev[PMRF_IRQ_RESET] = in_reset_q && !any_reset;
	wire [7:0] rd_mux = hit(ADDR_I, PMRF_ADDR_POWER_CONTROL) ? power_control_q :
		hit(ADDR_I, PMRF_ADDR_BROWNOUT_CONTROL) ? bod_q :
		hit(ADDR_I, PMRF_ADDR_IRQ_STATUS) ? {5'h00, irq_st_q} :
		hit(ADDR_I, PMRF_ADDR_IRQ_MASK) ? {5'h00, irq_mask_q} :
		hit(ADDR_I, PMRF_ADDR_RESET_CAUSE) ? {5'h00, cause_q} : 8'h00;

	// =====================================================
	// power-mode sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			PMRF_RUN: begin
				if (wr_power_control && WDATA_I[PMRF_BIT_PDOWN]) begin
					state_d = PMRF_PDOWN;
				end else if (wr_power_control && WDATA_I[PMRF_BIT_IDLE]) begin
					state_d = PMRF_IDLE;
				end
			end
			PMRF_IDLE: begin
				if (idle_wake) begin
					state_d = PMRF_RUN;
				end
			end
			PMRF_PDOWN: begin
				if (pd_wake) begin
					state_d = PMRF_SETTLE;
				end
			end
			PMRF_SETTLE: begin
				if (settle_q == 16'h0000) begin
					state_d = PMRF_RUN;
				end
			end
			default: begin
				state_d = PMRF_RUN;
			end
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (any_reset) begin
			state_q <= PMRF_RUN;
			settle_q <= 16'h0000;
			unlock_q <= 2'h0;
			unlock_cnt_q <= 3'h0;
			irq_mask_q <= '0;
			from_pdown_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == PMRF_PDOWN && pd_wake) begin
				settle_q <= SETTLE_CYC[15:0];
			end else if (settle_q != 16'h0000) begin
				settle_q <= settle_q - 16'h0001;
			end
			from_pdown_q <= (state_q == PMRF_SETTLE);
			if (wr_unlock && WDATA_I == PMRF_UNLOCK_KEY1) begin
				unlock_q <= 2'h1;
			end else if (wr_unlock && unlock_q[0] && WDATA_I == PMRF_UNLOCK_KEY2) begin
				unlock_q <= 2'h2;
				unlock_cnt_q <= PMRF_UNLOCK_WINDOW[2:0];
			end else if (wr_bod || unlock_cnt_q == 3'h1) begin
				unlock_q <= 2'h0;
			end
			if (unlock_cnt_q != 3'h0) begin
				unlock_cnt_q <= unlock_cnt_q - 3'h1;
			end
			if (wr_imask) begin
				irq_mask_q <= WDATA_I[PMRF_IRQ_W-1:0];
			end
		end
	end

	// =====================================================
	// power control and cause flags
	always_ff @(posedge CLOCK_I) begin
		if (por) begin
			power_control_q <= PMRF_POWER_CONTROL_RESET;
			bod_q <= PMRF_BOD_RESET;
		end else if (any_reset) begin
			power_control_q <= PMRF_POWER_CONTROL_RESET & {3'h0, power_control_q[PMRF_BIT_COLD], 4'h0};
			if (bor_fire) begin
				bod_q[PMRF_BIT_BOR_FLAG] <= 1'b1;
			end
		end else begin
			if (wr_power_control) begin
				power_control_q <= WDATA_I & PMRF_POWER_CONTROL_WMASK;
			end else if (state_q == PMRF_SETTLE && settle_q == 16'h0000) begin
				power_control_q[PMRF_BIT_PDOWN] <= 1'b0;
				power_control_q[PMRF_BIT_IDLE] <= 1'b0;
			end else if (state_q == PMRF_IDLE && idle_wake) begin
				power_control_q[PMRF_BIT_IDLE] <= 1'b0;
			end
			if (bod_wr_ok) begin
				bod_q <= WDATA_I & PMRF_BOD_WMASK;
			end
			if (BROWNOUT_DETECT_I) begin
				bod_q[PMRF_BIT_BO_EVENT] <= 1'b1;
			end
			bod_q[PMRF_BIT_BO_STATE] <= BROWNOUT_DETECT_I;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			cause_q <= PMRF_CAUSE_POR;
			in_reset_q <= 1'b1;
			irq_st_q <= '0;
		end else begin
			in_reset_q <= any_reset;
			if (any_reset) begin
				cause_q <= cause_now;
			end
			// set wins over write-one-to-clear
			irq_st_q <= (irq_st_q & ~(wr_ist ? WDATA_I[PMRF_IRQ_W-1:0] : '0)) | irq_ev;
		end
	end

	// =====================================================
	// registered outputs
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			RDATA_O <= 8'h00;
			CORE_RESET_O <= 1'b1;
			CPU_CLK_EN_O <= 1'b0;
			PERIPH_CLK_EN_O <= 1'b0;
			OSC_EN_O <= 1'b0;
			WAKE_SERVICE_O <= 1'b0;
			FETCH_ADDR_O <= PMRF_RESET_VECTOR;
			RESET_CAUSE_O <= PMRF_CAUSE_POR;
			IRQ_O <= 1'b0;
		end else begin
			RDATA_O <= RD_I ? rd_mux : 8'h00;
			CORE_RESET_O <= any_reset;
			// power-down stops all clocks; idle stops CPU only
			CPU_CLK_EN_O <= !any_reset && state_d == PMRF_RUN;
			PERIPH_CLK_EN_O <= !any_reset && state_d != PMRF_PDOWN && state_d != PMRF_SETTLE;
			OSC_EN_O <= SUPPLY_OK_I && state_d != PMRF_PDOWN;
			// wake pulse: core runs handler then returns past request
			WAKE_SERVICE_O <= irq_ev[PMRF_IRQ_WAKE];
			FETCH_ADDR_O <= PMRF_RESET_VECTOR;
			RESET_CAUSE_O <= cause_q;
			IRQ_O <= |(irq_st_q & irq_mask_q);
		end
	end
endmodule : pmrf_top
`default_nettype wire

// ===== bench/pmrf_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pmrf_top_asserts
	import pmrf_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	// inputs watched
	input wire logic PIN_RESET_I,
	input wire logic INT_PENDING_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	// outputs watched
	input wire logic [7:0] RDATA_O,
	input wire logic CORE_RESET_O,
	input wire logic CPU_CLK_EN_O,
	input wire logic PERIPH_CLK_EN_O,
	input wire logic OSC_EN_O,
	input wire logic [15:0] FETCH_ADDR_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	wire pc_wr = WR_I && !CORE_RESET_O && ADDR_I == PMRF_ADDR_POWER_CONTROL;
	wire idle = PERIPH_CLK_EN_O && !CPU_CLK_EN_O;
	property p_pdown_stop;
		pc_wr && WDATA_I[PMRF_BIT_PDOWN] |=> !PERIPH_CLK_EN_O && !OSC_EN_O && !CPU_CLK_EN_O;
	endproperty
	a_pdown_stop: assert property (p_pdown_stop) else $error("clocks run after sleep");
	property p_idle_stop; pc_wr && WDATA_I[1:0] == 2'h1 |=> idle; endproperty
	a_idle_stop: assert property (p_idle_stop) else $error("idle clocks wrong");
	property p_no_idle; $rose(PERIPH_CLK_EN_O) |-> CPU_CLK_EN_O; endproperty
	a_no_idle: assert property (p_no_idle) else $error("fell into idle on wake");
	property p_idle_exit; idle && INT_PENDING_I && !CORE_RESET_O |=> CPU_CLK_EN_O; endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle not left");
	property p_dark; !OSC_EN_O |-> !CPU_CLK_EN_O && !PERIPH_CLK_EN_O; endproperty
	a_dark: assert property (p_dark) else $error("clock without oscillator");
	property p_fetch;
		$fell(CORE_RESET_O) |-> FETCH_ADDR_O == PMRF_RESET_VECTOR && CPU_CLK_EN_O;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch address not zero");
	property p_pin; PIN_RESET_I |=> CORE_RESET_O; endproperty
	a_pin: assert property (p_pin) else $error("pin reset missed");
	property p_rd_idle; !RD_I |=> RDATA_O == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
endmodule : pmrf_top_asserts
bind pmrf_top pmrf_top_asserts u_chk (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
	.PIN_RESET_I(PIN_RESET_I), .INT_PENDING_I(INT_PENDING_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CORE_RESET_O(CORE_RESET_O),
	.CPU_CLK_EN_O(CPU_CLK_EN_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O), .OSC_EN_O(OSC_EN_O),
	.FETCH_ADDR_O(FETCH_ADDR_O));
`default_nettype wire

// ===== bench/pmrf_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pmrf_top_tb import pmrf_pkg::*;;
	logic clk = 1'b0, rst_n = 1'b0, pin = 1'b0, wdt = 1'b0, swr = 1'b0, bo = 1'b0;
	logic intp = 1'b0, wr = 1'b0, rd = 1'b0, cre, cpu, per, osc, wsv, irq;
	logic [5:0] wake = 6'h00;
	logic sup = 1'b1, rst_seen = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
	logic [15:0] fetch;
	logic [2:0] cause;
	int n_mismatch = 0, n_compared = 0, cyc = 0;
	always #2.5 clk = ~clk;
	pmrf_top #(.SETTLE_CYC(2)) pmrf_top_i (.CLOCK_I(clk), .RST_N_I(rst_n), .SUPPLY_OK_I(sup),
		.PIN_RESET_I(pin), .WDT_RESET_I(wdt), .SW_RESET_I(swr), .BROWNOUT_DETECT_I(bo),
		.INT_PENDING_I(intp), .PDOWN_WAKE_I(wake), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .CORE_RESET_O(cre), .CPU_CLK_EN_O(cpu), .PERIPH_CLK_EN_O(per),
		.OSC_EN_O(osc), .WAKE_SERVICE_O(wsv), .FETCH_ADDR_O(fetch), .RESET_CAUSE_O(cause),
		.IRQ_O(irq));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wrb(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wrb
	task rdb(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask : rdb
	// pulse of {brown-out, pin, watchdog, software} sources
	task pulse(input logic [3:0] s);
		@(posedge clk);
		{bo, pin, wdt, swr} <= s;
		rst_seen = 1'b0;
		repeat (3) begin
			@(posedge clk);
			#1 rst_seen = rst_seen | cre;
		end
		@(posedge clk);
		{bo, pin, wdt, swr} <= 4'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask : pulse
	task t_idle;
		wrb(PMRF_ADDR_POWER_CONTROL, 8'h01);
		chk({cpu, per}, 2'h1);
		@(posedge clk) intp <= 1'b1;
		@(posedge clk) intp <= 1'b0;
		#1 chk(cpu, 1'b1);
		rdb(PMRF_ADDR_POWER_CONTROL);
		chk(rv, 8'h00);
		$display("idle test done");
	endtask : t_idle
	task t_pdown;
		logic seen;
		for (int b = 0; b < 6; b++) begin
			wrb(PMRF_ADDR_POWER_CONTROL, (b == 0) ? 8'h03 : 8'h02);
			chk({cpu, per, osc}, 3'h0);
			@(posedge clk) wake <= 6'h01 << b;
			seen = 1'b0;
			for (int i = 0; i < 20 && !cpu; i++) begin
				@(posedge clk);
				#1 seen = seen | wsv;
			end
			@(posedge clk) wake <= 6'h00;
			chk({seen, cpu, per}, 3'h7);
			rdb(PMRF_ADDR_POWER_CONTROL);
			chk(rv, 8'h00);
		end
		$display("power-down test done");
	endtask : t_pdown
	// warm resets keep the cleared cold flag
	task t_warm;
		logic [3:0] src [3] = '{4'h4, 4'h2, 4'h1};
		logic [2:0] code [3] = '{PMRF_CAUSE_PIN, PMRF_CAUSE_WDT, PMRF_CAUSE_SW};
		for (int k = 0; k < 3; k++) begin
			pulse(src[k]);
			chk(cause, code[k]);
			chk(rst_seen, 1'b1);
			rdb(PMRF_ADDR_POWER_CONTROL);
			chk(rv, 8'h00);
		end
		@(posedge clk) sup <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({osc, cre}, 2'h1);
		@(posedge clk) sup <= 1'b1;
		rdb(PMRF_ADDR_POWER_CONTROL);
		chk(rv, PMRF_POWER_CONTROL_RESET);
		chk(cause, PMRF_CAUSE_POR);
		wrb(PMRF_ADDR_POWER_CONTROL, 8'h00);
		@(posedge clk) rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rdb(PMRF_ADDR_POWER_CONTROL);
		chk(rv, PMRF_POWER_CONTROL_RESET);
		chk(fetch, PMRF_RESET_VECTOR);
		chk(cause, PMRF_CAUSE_POR);
		$display("warm reset test done");
	endtask : t_warm
	task t_bor;
		wrb(PMRF_ADDR_UNLOCK, PMRF_UNLOCK_KEY1);
		wrb(PMRF_ADDR_UNLOCK, PMRF_UNLOCK_KEY2);
		wrb(PMRF_ADDR_BROWNOUT_CONTROL, 8'h04);
		wrb(PMRF_ADDR_BROWNOUT_CONTROL, 8'h00);
		rdb(PMRF_ADDR_BROWNOUT_CONTROL);
		chk(rv & 8'h06, 8'h04);
		pulse(4'h8);
		chk(rst_seen, 1'b1);
		chk(cause, PMRF_CAUSE_BOR);
		rdb(PMRF_ADDR_BROWNOUT_CONTROL);
		chk(rv & 8'h02, 8'h02);
		wrb(PMRF_ADDR_UNLOCK, PMRF_UNLOCK_KEY1);
		wrb(PMRF_ADDR_UNLOCK, PMRF_UNLOCK_KEY2);
		wrb(PMRF_ADDR_BROWNOUT_CONTROL, 8'h00);
		wrb(PMRF_ADDR_IRQ_MASK, 8'h02);
		pulse(4'h8);
		chk(rst_seen, 1'b0);
		rdb(PMRF_ADDR_BROWNOUT_CONTROL);
		chk({irq, rv & 8'h06}, 9'h100);
		wrb(PMRF_ADDR_IRQ_STATUS, 8'h02);
		wrb(PMRF_ADDR_IRQ_MASK, 8'h00);
		pulse(4'h8);
		chk(rst_seen, 1'b0);
		rdb(8'h00);
		chk({irq, rv}, 9'h000);
		$display("brown-out test done");
	endtask : t_bor
	task tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rdb(PMRF_ADDR_POWER_CONTROL);
		chk(rv, PMRF_POWER_CONTROL_RESET);
		t_idle;
		t_pdown;
		t_warm;
		t_bor;
		tally_and_finish;
	end
endmodule : pmrf_top_tb
`default_nettype wire
